/* verilog/oat_pkg.sv */
// Purpose: Constants for the oversampling average, min/max and threshold block
// Assumes: APB register access, 40 MHz clock, Q16.16 results
// Notes: How it works is summarised below
//
// How it works
// - Selector value 3 gathers count samples at the scan rate and yields average, min and max.
// - Selector value 5 gathers count samples, averages them and flags an average above threshold.
// - The sample count resets to 200 and a write above 16384 saturates at 16384.
// - The scan rate sets the sampling frequency for both modes and resets to 6000 per second.
// - Acquisition lasts sample count divided by scan rate.
// - Only a primary result read starts an acquisition; other result reads return stored values.
// - A primary result read with selector 3 or 5 stalls until the acquisition and its arithmetic are finished; other selectors return zero at once.
// - Min/max mode returns average, largest and smallest sample in primary, secondary, tertiary.
// - Threshold mode returns 1.0 or 0.0 in primary and the average in secondary.
// - Threshold mode with a zero digital override samples the analog input, zero being default.
// - Threshold mode with a nonzero override samples the digital line at that address.
// - The average is compared with the threshold and drives the primary flag.
// - Analog samples come through the burst acquisition path with its own settings.
package oat_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_SELECT = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_OVERRIDE = 8'h08;
    localparam logic [7:0] OFF_RATE = 8'h0C;
    localparam logic [7:0] OFF_THRESH = 8'h10;
    localparam logic [7:0] OFF_PRIMARY = 8'h14;
    localparam logic [7:0] OFF_SECONDARY = 8'h18;
    localparam logic [7:0] OFF_TERTIARY = 8'h1C;
    localparam logic [7:0] OFF_BUSY = 8'h20;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
    localparam logic [7:0] OFF_IRQ_EN = 8'h2C;

    // ----------------------------------------------------------------
    // Reset values, limits and codes
    // ----------------------------------------------------------------
    localparam logic [14:0] DEF_COUNT = 15'h00C8;
    localparam logic [14:0] MAX_COUNT = 15'h4000;
    localparam logic [31:0] DEF_RATE = 32'h0000_1770;
    localparam int MAX_TIME_MS = 180;
    localparam logic [7:0] MODE_MINMAX = 8'h03;
    localparam logic [7:0] MODE_THRESH = 8'h05;
    localparam logic [31:0] Q_ONE = 32'h0001_0000;
    localparam int IRQ_BITS = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_BADMODE = 1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PERIOD = 3'b001,
        ST_ACQ = 3'b010,
        ST_WAIT = 3'b011,
        ST_DIV = 3'b100,
        ST_DONE = 3'b101
    } oat_state_t;

endpackage

/* verilog/oat_divider.sv */
// Purpose: Unsigned restoring divider, one quotient bit per clock
// Assumes: start is a one-cycle pulse while not busy
// Notes: done pulses with the quotient valid, W cycles after start
`timescale 1ns/10ps
module oat_divider #(
    parameter int W = 48
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Request
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    // Answer
    output logic done,
    output logic [W-1:0] quotient
);
    logic [W-1:0] rem;
    logic [$clog2(W+1)-1:0] cnt;
    logic [W:0] shifted;
    logic [W:0] diff;

    // Trial subtraction of the divisor
    always_comb
    begin
        shifted = {rem, quotient[W-1]};
        diff = shifted - {1'b0, divisor};
    end

    // Shift and subtract loop
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rem <= '0;
            quotient <= '0;
            cnt <= '0;
            done <= 1'b0;
        end
        else if (start)
        begin
            rem <= '0;
            quotient <= dividend;
            cnt <= ($clog2(W+1))'(W);
            done <= 1'b0;
        end
        else if (cnt != '0)
        begin
            rem <= diff[W] ? shifted[W-1:0] : diff[W-1:0];
            quotient <= {quotient[W-2:0], ~diff[W]};
            cnt <= cnt - 1'b1;
            done <= (cnt == ($clog2(W+1))'(1));
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule

/* verilog/oat_rate_tick.sv */
// Purpose: Sample pacing pulse generator
// Assumes: period is at least 1 and stable while run is high
// Notes: first tick comes period cycles after run rises
`timescale 1ns/10ps
module oat_rate_tick (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic run,
    input wire logic [31:0] period,
    // Pulse out
    output logic tick
);
    logic [31:0] cnt;

    // Count one sample period, then pulse
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt <= '0;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt <= '0;
            tick <= 1'b0;
        end
        else if (cnt >= period - 32'h0000_0001)
        begin
            cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule

/* verilog/oat_core.sv */
// Purpose: Oversampling average with min/max and threshold modes behind APB
// Assumes: burst engine answers a request with one burstValid pulse
// Notes: results are signed Q16.16, analog codes taken as integers
`timescale 1ns/10ps
module oat_core #(
    parameter int SW = 16,
    parameter int NUM_DIO = 8,
    parameter logic [15:0] DIO_BASE = 16'h07D0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Burst acquisition engine
    output logic burstReq,
    input wire logic burstValid,
    input wire logic signed [SW-1:0] burstData,
    // Digital lines
    input wire logic [NUM_DIO-1:0] digitalLines,
    // Interrupt
    output logic irq
);
    localparam int AW = 48;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    oat_pkg::oat_state_t state;
    logic [7:0] featureSelector;
    logic [14:0] sampleCount;
    logic [15:0] digitalSourceOverride;
    logic [31:0] scanRate;
    logic signed [31:0] threshold;
    logic [31:0] primaryRes, secondaryRes, tertiaryRes;
    logic [oat_pkg::IRQ_BITS-1:0] irqStatus, irqEnable, irqSet;
    logic [7:0] mode;
    logic useDigital;
    logic signed [AW-1:0] sum;
    logic signed [31:0] maxQ, minQ, avgQ;
    logic [14:0] taken;
    logic [31:0] period;
    logic runTick, tick;
    logic divStart, divDone, divNeg;
    logic [AW-1:0] divDividend, divDivisor, divQuot;
    logic setupRd, primaryRd, wrEn, mapped, newValid, lineVal;
    logic signed [AW-1:0] newQ;
    logic [15:0] lineIdx;
    logic [31:0] rdMux;

    // Place a sample code at Q16.16 in the accumulator width
    function automatic logic signed [AW-1:0] toQ(input logic signed [SW-1:0] s);
        toQ = {{(AW-16-SW){s[SW-1]}}, s, 16'h0000};
    endfunction

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    always_comb
    begin
        setupRd = psel && !penable && !pwrite;
        primaryRd = setupRd && paddr == oat_pkg::OFF_PRIMARY;
        wrEn = psel && penable && pready && pwrite;
        lineIdx = digitalSourceOverride - DIO_BASE;
        lineVal = (lineIdx < 16'(NUM_DIO)) ? digitalLines[lineIdx[$clog2(NUM_DIO)-1:0]] : 1'b0;
        mapped = 1'b1;
        unique case (paddr)
            oat_pkg::OFF_SELECT: rdMux = {24'h00_0000, featureSelector};
            oat_pkg::OFF_COUNT: rdMux = {17'h0_0000, sampleCount};
            oat_pkg::OFF_OVERRIDE: rdMux = {16'h0000, digitalSourceOverride};
            oat_pkg::OFF_RATE: rdMux = scanRate;
            oat_pkg::OFF_THRESH: rdMux = threshold;
            oat_pkg::OFF_PRIMARY: rdMux = primaryRes;
            oat_pkg::OFF_SECONDARY: rdMux = secondaryRes;
            oat_pkg::OFF_TERTIARY: rdMux = tertiaryRes;
            oat_pkg::OFF_BUSY: rdMux = {31'h0000_0000, state != oat_pkg::ST_IDLE};
            oat_pkg::OFF_IRQ_STAT: rdMux = {30'h0000_0000, irqStatus};
            oat_pkg::OFF_IRQ_CLR: rdMux = 32'h0000_0000;
            oat_pkg::OFF_IRQ_EN: rdMux = {30'h0000_0000, irqEnable};
            default:
            begin
                rdMux = 32'h0000_0000;
                mapped = 1'b0;
            end
        endcase
    end

    // Configuration registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            featureSelector <= 8'h00;
            sampleCount <= oat_pkg::DEF_COUNT;
            digitalSourceOverride <= 16'h0000;
            scanRate <= oat_pkg::DEF_RATE;
            threshold <= 32'h0000_0000;
            irqEnable <= '0;
        end
        else if (wrEn)
        begin
            unique case (paddr)
                oat_pkg::OFF_SELECT: featureSelector <= pwdata[7:0];
                oat_pkg::OFF_COUNT:
                    sampleCount <= (pwdata > 32'(oat_pkg::MAX_COUNT)) ? oat_pkg::MAX_COUNT :
                                   (pwdata == 32'h0000_0000) ? 15'h0001 : pwdata[14:0];
                oat_pkg::OFF_OVERRIDE: digitalSourceOverride <= pwdata[15:0];
                oat_pkg::OFF_RATE: scanRate <= (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
                oat_pkg::OFF_THRESH: threshold <= pwdata;
                oat_pkg::OFF_IRQ_EN: irqEnable <= pwdata[oat_pkg::IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && penable && pready)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (state == oat_pkg::ST_DONE)
        begin
            pready <= 1'b1;
            prdata <= primaryRes;
        end
        else if (psel && !penable && !(primaryRd && (featureSelector == oat_pkg::MODE_MINMAX ||
                 featureSelector == oat_pkg::MODE_THRESH)))
        begin
            pready <= 1'b1;
            prdata <= primaryRd ? 32'h0000_0000 : rdMux;
            pslverr <= !mapped;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        newValid = (state == oat_pkg::ST_ACQ && tick && useDigital) ||
                   (state == oat_pkg::ST_WAIT && burstValid);
        newQ = useDigital ? (lineVal ? AW'(oat_pkg::Q_ONE) : '0) : toQ(burstData);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= oat_pkg::ST_IDLE;
            mode <= 8'h00;
            useDigital <= 1'b0;
            runTick <= 1'b0;
            burstReq <= 1'b0;
            divStart <= 1'b0;
            divDividend <= '0;
            divDivisor <= '0;
            divNeg <= 1'b0;
            period <= 32'h0000_0001;
            sum <= '0;
            maxQ <= 32'h0000_0000;
            minQ <= 32'h0000_0000;
            taken <= 15'h0000;
        end
        else
        begin
            divStart <= 1'b0;
            burstReq <= 1'b0;
            unique case (state)
                oat_pkg::ST_IDLE:
                    if (primaryRd && (featureSelector == oat_pkg::MODE_MINMAX ||
                        featureSelector == oat_pkg::MODE_THRESH))
                    begin
                        // Sample period = clock rate / scan rate
                        state <= oat_pkg::ST_PERIOD;
                        mode <= featureSelector;
                        useDigital <= featureSelector == oat_pkg::MODE_THRESH &&
                                      digitalSourceOverride != 16'h0000;
                        divStart <= 1'b1;
                        divDividend <= AW'(oat_pkg::CLK_HZ);
                        divDivisor <= AW'(scanRate);
                    end
                oat_pkg::ST_PERIOD:
                    if (divDone)
                    begin
                        period <= (divQuot == '0) ? 32'h0000_0001 : divQuot[31:0];
                        runTick <= 1'b1;
                        sum <= '0;
                        taken <= 15'h0000;
                        state <= oat_pkg::ST_ACQ;
                    end
                oat_pkg::ST_ACQ:
                    if (tick && !useDigital)
                    begin
                        burstReq <= 1'b1;
                        state <= oat_pkg::ST_WAIT;
                    end
                oat_pkg::ST_WAIT: ;
                oat_pkg::ST_DIV:
                    if (divDone)
                        state <= oat_pkg::ST_DONE;
                oat_pkg::ST_DONE:
                    state <= oat_pkg::ST_IDLE;
                default:
                    state <= oat_pkg::ST_IDLE;
            endcase
            // Accumulate, track extremes, stop after the count (duration = count/rate)
            if (newValid)
            begin
                sum <= sum + newQ;
                maxQ <= (taken == 15'h0000 || $signed(newQ[31:0]) > maxQ) ? newQ[31:0] : maxQ;
                minQ <= (taken == 15'h0000 || $signed(newQ[31:0]) < minQ) ? newQ[31:0] : minQ;
                taken <= taken + 15'h0001;
                if (taken + 15'h0001 == sampleCount)
                begin
                    runTick <= 1'b0;
                    divStart <= 1'b1;
                    divNeg <= sum[AW-1] ^ newQ[AW-1] ? (sum + newQ) < 0 : sum[AW-1];
                    divDividend <= ((sum + newQ) < 0) ? AW'(-(sum + newQ)) : AW'(sum + newQ);
                    divDivisor <= AW'(sampleCount);
                    state <= oat_pkg::ST_DIV;
                end
                else
                begin
                    state <= oat_pkg::ST_ACQ;
                end
            end
        end
    end

    // Results from the finished average
    always_comb
    begin
        avgQ = divNeg ? -$signed(divQuot[31:0]) : $signed(divQuot[31:0]);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            primaryRes <= 32'h0000_0000;
            secondaryRes <= 32'h0000_0000;
            tertiaryRes <= 32'h0000_0000;
        end
        else if (state == oat_pkg::ST_DIV && divDone)
        begin
            if (mode == oat_pkg::MODE_MINMAX)
            begin
                primaryRes <= avgQ;
                secondaryRes <= maxQ;
                tertiaryRes <= minQ;
            end
            else
            begin
                primaryRes <= (avgQ > threshold) ? oat_pkg::Q_ONE : 32'h0000_0000;
                secondaryRes <= avgQ;
                tertiaryRes <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    always_comb
    begin
        irqSet = '0;
        irqSet[oat_pkg::IRQ_DONE] = state == oat_pkg::ST_DONE;
        irqSet[oat_pkg::IRQ_BADMODE] = primaryRd && state == oat_pkg::ST_IDLE &&
            featureSelector != oat_pkg::MODE_MINMAX && featureSelector != oat_pkg::MODE_THRESH;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqStatus <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irqStatus <= (irqStatus & ~((wrEn && paddr == oat_pkg::OFF_IRQ_CLR) ?
                         pwdata[oat_pkg::IRQ_BITS-1:0] : '0)) | irqSet;
            irq <= |(irqStatus & irqEnable);
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    oat_rate_tick u_tick (
        .clk(clk),
        .arst_n(arst_n),
        .run(runTick),
        .period(period),
        .tick(tick)
    );

    oat_divider #(.W(AW)) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .start(divStart),
        .dividend(divDividend),
        .divisor(divDivisor),
        .done(divDone),
        .quotient(divQuot)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_START_ONLY_PRIMARY: assert property (
        state == oat_pkg::ST_IDLE ##1 state == oat_pkg::ST_PERIOD |-> $past(primaryRd))
        else $error("acquisition started without a primary read");
    AST_STALL: assert property (
        state inside {oat_pkg::ST_ACQ, oat_pkg::ST_WAIT, oat_pkg::ST_DIV} |-> !pready)
        else $error("bus answered during acquisition");
    AST_ANSWER_DATA: assert property (
        state == oat_pkg::ST_DONE |=> pready && prdata == primaryRes)
        else $error("primary answer missing after computation");
    AST_MINMAX: assert property (
        state == oat_pkg::ST_DONE && mode == oat_pkg::MODE_MINMAX |->
        $signed(tertiaryRes) <= $signed(secondaryRes))
        else $error("min above max");
    AST_FLAG: assert property (
        state == oat_pkg::ST_DONE && mode == oat_pkg::MODE_THRESH |->
        primaryRes == (($signed(secondaryRes) > threshold) ? oat_pkg::Q_ONE : 32'h0000_0000))
        else $error("threshold flag disagrees with average");
    AST_CLEAR: assert property (
        state == oat_pkg::ST_PERIOD && divDone |=> sum == '0 && taken == 15'h0000)
        else $error("sum not cleared at start");
    AST_DIGITAL_NO_BURST: assert property (
        useDigital && state != oat_pkg::ST_IDLE |-> !burstReq)
        else $error("burst request while sampling a digital line");
    AST_COUNT_LIMIT: assert property (
        sampleCount <= oat_pkg::MAX_COUNT && sampleCount != 15'h0000)
        else $error("sample count out of range");
    AST_SAMPLES_TAKEN: assert property (
        state inside {oat_pkg::ST_ACQ, oat_pkg::ST_WAIT} ##1 state == oat_pkg::ST_DIV |->
        taken == sampleCount)
        else $error("average started with wrong sample count");
    AST_IRQ: assert property (
        irqStatus[oat_pkg::IRQ_DONE] && irqEnable[oat_pkg::IRQ_DONE] |=> irq)
        else $error("interrupt not raised");

    COV_MINMAX: cover property (state == oat_pkg::ST_DONE && mode == oat_pkg::MODE_MINMAX);
    COV_THRESH_HIT: cover property (state == oat_pkg::ST_DONE && primaryRes == oat_pkg::Q_ONE);
    COV_DIGITAL: cover property (state == oat_pkg::ST_DONE && useDigital);
endmodule

/* verification/oat_burst_model.sv */
// Purpose: Burst engine stand-in giving one sample per request
// Assumes: one request outstanding at a time
// Notes: data shows the inverse of the last sample once released
`timescale 1ns/10ps
module oat_burst_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bench control
    input wire logic slow,
    input wire logic signed [15:0] bias,
    // Engine side
    input wire logic burstReq,
    output logic burstValid,
    output logic signed [15:0] burstData,
    output int reqCount
);
    logic signed [15:0] pat [4] = '{16'h000A, 16'hFFFA, 16'h001E, 16'h0002};
    int waitN;
    int idx;

    // Answer each request after a short or long delay
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            burstValid <= 1'b0;
            burstData <= 16'h0000;
            reqCount <= 0;
            waitN <= 0;
            idx <= 0;
        end
        else
        begin
            burstValid <= 1'b0;
            if (burstValid)
                burstData <= ~burstData; // Released line does not hold
            if (burstReq)
            begin
                reqCount <= reqCount + 1;
                waitN <= slow ? 6 : 1;
            end
            else if (waitN == 1)
            begin
                burstValid <= 1'b1;
                burstData <= pat[idx] + bias;
                idx <= (idx + 1) % 4;
                waitN <= 0;
            end
            else if (waitN > 1)
                waitN <= waitN - 1;
        end
    end
endmodule

/* verification/testbench.sv */
// Purpose: Self-checking bench for the averaging block
// Assumes: APB master, burst model as sample source
// Notes: high scan rate keeps acquisitions short
`timescale 1ns/10ps
module testbench;
    // Bench signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, burstReq, burstValid, irq, lastErr, slow = 1'b0;
    logic signed [15:0] burstData;
    logic signed [15:0] bias = 16'h0000;
    logic [7:0] digitalLines = 8'h00;
    logic [31:0] rdVal;
    int reqCount, waitCycles, bad_count = 0, samples_checked = 0;

    always #12.5 clk = ~clk;

    oat_core dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .burstReq(burstReq), .burstValid(burstValid),
        .burstData(burstData), .digitalLines(digitalLines), .irq(irq));
    oat_burst_model model_u (.clk(clk), .arst_n(arst_n), .slow(slow), .bias(bias),
        .burstReq(burstReq), .burstValid(burstValid), .burstData(burstData),
        .reqCount(reqCount));

    // Compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, waiting on pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        waitCycles = 0;
        do
        begin
            @(posedge clk);
            waitCycles++;
        end
        while (pready !== 1'b1 && waitCycles < 4000);
        if (waitCycles >= 4000)
            bad_count++;
        rdVal = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input string name, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, rdVal, exp);
    endtask

    task automatic t_reset();
        rdchk(oat_pkg::OFF_COUNT, "count", 32'h0000_00C8);
        rdchk(oat_pkg::OFF_RATE, "rate", 32'h0000_1770);
        rdchk(oat_pkg::OFF_OVERRIDE, "override", 32'h0000_0000);
        apb(1'b1, oat_pkg::OFF_COUNT, 32'h0000_4E20);
        rdchk(oat_pkg::OFF_COUNT, "count clamp", 32'h0000_4000);
    endtask

    task automatic t_minmax();
        int n;
        apb(1'b1, oat_pkg::OFF_SELECT, 32'h0000_0003);
        apb(1'b1, oat_pkg::OFF_COUNT, 32'h0000_0004);
        apb(1'b1, oat_pkg::OFF_RATE, 32'h003D_0900);
        n = reqCount;
        rdchk(oat_pkg::OFF_PRIMARY, "avg", 32'h0009_0000);
        chk("stall", 32'(waitCycles >= 40), 32'h0000_0001);
        rdchk(oat_pkg::OFF_SECONDARY, "max", 32'h001E_0000);
        rdchk(oat_pkg::OFF_TERTIARY, "min", 32'hFFFA_0000);
        chk("requests", 32'(reqCount - n), 32'h0000_0004);
        bias <= 16'h0064;
        slow <= 1'b1;
        rdchk(oat_pkg::OFF_PRIMARY, "avg 2", 32'h006D_0000);
        rdchk(oat_pkg::OFF_SECONDARY, "max 2", 32'h0082_0000);
        rdchk(oat_pkg::OFF_TERTIARY, "min 2", 32'h005E_0000);
    endtask

    task automatic t_thresh();
        logic [31:0] th [3] = '{32'h0008_0000, 32'h0008_FFFF, 32'h0009_0000};
        logic [31:0] fl [3] = '{32'h0001_0000, 32'h0001_0000, 32'h0000_0000};
        bias <= 16'h0000;
        apb(1'b1, oat_pkg::OFF_SELECT, 32'h0000_0005);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, oat_pkg::OFF_THRESH, th[i]);
            rdchk(oat_pkg::OFF_PRIMARY, "flag", fl[i]);
            rdchk(oat_pkg::OFF_SECONDARY, "avg", 32'h0009_0000);
        end
    endtask

    task automatic t_digital();
        int n;
        apb(1'b1, oat_pkg::OFF_OVERRIDE, 32'h0000_07D1);
        apb(1'b1, oat_pkg::OFF_THRESH, 32'h0000_8000);
        digitalLines <= 8'h02;
        n = reqCount;
        rdchk(oat_pkg::OFF_PRIMARY, "dig flag", 32'h0001_0000);
        rdchk(oat_pkg::OFF_SECONDARY, "dig avg", 32'h0001_0000);
        chk("no burst", 32'(reqCount - n), 32'h0000_0000);
        digitalLines <= 8'hFD;
        rdchk(oat_pkg::OFF_PRIMARY, "dig flag 0", 32'h0000_0000);
        rdchk(oat_pkg::OFF_SECONDARY, "dig avg 0", 32'h0000_0000);
        apb(1'b1, oat_pkg::OFF_OVERRIDE, 32'h0000_0000);
    endtask

    task automatic t_irq();
        apb(1'b1, oat_pkg::OFF_IRQ_EN, 32'h0000_0001);
        rdchk(oat_pkg::OFF_PRIMARY, "flag", 32'h0001_0000);
        repeat (2) @(posedge clk);
        chk("irq set", 32'(irq), 32'h0000_0001);
        apb(1'b1, oat_pkg::OFF_IRQ_CLR, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("irq clear", 32'(irq), 32'h0000_0000);
        rdchk(8'h40, "unmapped", 32'h0000_0000);
        chk("slverr", 32'(lastErr), 32'h0000_0001);
        apb(1'b1, oat_pkg::OFF_SELECT, 32'h0000_0000);
        rdchk(oat_pkg::OFF_PRIMARY, "bad mode", 32'h0000_0000);
        apb(1'b0, oat_pkg::OFF_IRQ_STAT, 32'h0000_0000);
        chk("mode stat", 32'(rdVal[1]), 32'h0000_0001);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        apb(1'b1, oat_pkg::OFF_IRQ_EN, 32'h0000_0003);
        repeat (2) @(posedge clk);
        chk("irq mode", 32'(irq), 32'h0000_0001);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_minmax();
        t_thresh();
        t_digital();
        t_irq();
        report_and_stop();
    end

    // Watchdog
    initial
    begin
        #(25 * 30000);
        bad_count++;
        report_and_stop();
    end
endmodule
